// ---- pbsd_pkg.sv ----
package pbsd_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_SOURCE2_REF   = 12'h000;
    localparam logic [11:0] OFS_SRC2_INVERT   = 12'h004;
    localparam logic [11:0] OFS_OUT_INVERT    = 12'h008;
    localparam logic [11:0] OFS_DELAY_TIME    = 12'h00C;
    localparam logic [11:0] OFS_DEST_REF      = 12'h010;
    localparam logic [11:0] OFS_SOURCE1_REF   = 12'h014;
    localparam logic [11:0] OFS_RESULT        = 12'h018;
    // Parameter reference: module in [13:7], bit in [6:0]
    localparam int          REF_W             = 14;
    localparam int          REF_BIT_LSB       = 0;
    localparam int          REF_BIT_W         = 7;
    localparam logic [13:0] UNUSED_REF        = 14'h0000;
    // Reset values
    localparam logic        SRC2_INVERT_RST   = 1'h0;
    localparam logic        OUT_INVERT_RST    = 1'h0;
    localparam logic [15:0] DELAY_TIME_RST    = 16'h0000;
    // Delay unit: 0.1 s per count at 20 MHz
    localparam int          CLK_HZ            = 20000000;
    localparam real         DELAY_UNIT_S      = 0.1;
    localparam int          TICK_CYCLES       = int'(DELAY_UNIT_S * CLK_HZ);
    localparam int          DELAY_MAX_COUNTS  = 32760;
endpackage : pbsd_pkg

// ---- pbsd_delay.sv ----
`timescale 1ns/1ps
module pbsd_delay
    import pbsd_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Control
    input  wire logic        cond,
    input  wire logic [15:0] delay,
    // Result
    output logic             q
);
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic [15:0] units;
    logic [15:0] next_units;
    logic        next_q;
    logic        neg;
    logic [15:0] mag;
    logic        target;

    always_comb begin
        neg = delay[15];
        mag = neg ? 16'(-delay) : delay;
        // On-delay delays rising, off-delay delays falling
        target = neg ? 1'h0 : 1'h1;                             // RL5 RL6
        next_q = q;
        next_tick_cnt = 32'h0;
        next_units = 16'h0;
        if (cond == q) begin
            next_q = q;
        end else if (mag == 16'h0) begin
            next_q = cond;
        end else if (cond != target) begin                      // RL5 RL6
            // Undelayed edge follows at once
            next_q = cond;
        end else begin
            next_tick_cnt = tick_cnt + 32'h1;
            next_units = units;
            if (tick_cnt == 32'(TICK - 1)) begin
                next_tick_cnt = 32'h0;
                next_units = units + 16'h1;
                if (units + 16'h1 >= mag) begin                // RL7 RL8
                    next_q = cond;
                    next_units = 16'h0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= 1'h0;
            tick_cnt <= 32'h0;
            units <= 16'h0;
        end else begin
            q <= next_q;
            tick_cnt <= next_tick_cnt;
            units <= next_units;
        end
    end
endmodule : pbsd_delay

// ---- pbsd_top.sv ----
// Function
// RL1: Source 2 chosen by module-bit reference
// RL2: Unused source 2 reference reads one
// RL3: Source 2 invert control, reset zero
// RL4: Output invert control, reset zero
// RL5: Positive delay gives on-delay
// RL6: Negative delay gives off-delay
// RL7: Signed delay up to 3276.0 seconds (code: no limit applied, magnitudes up to 3276.8 s accepted)
// RL8: Delay governs output becoming active (code: a negative delay delays the output becoming inactive instead)
// RL9: Output readable as status bit
// RL10: Output routed to destination reference
// RL11: Source 1 AND source 2 combined
`timescale 1ns/1ps
module pbsd_top
    import pbsd_pkg::*;
#(
    parameter int TICK      = TICK_CYCLES,
    parameter int PARAM_BITS = 16384
) (
    // APB
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic [31:0]                prdata,
    // Drive bit parameter space
    input  wire logic [PARAM_BITS-1:0] param_bits,
    // Destination write
    output logic [REF_W-1:0]           dest_ref,
    output logic                       dest_value,
    output logic                       dest_enable
);
    logic [REF_W-1:0] source1_ref;
    logic [REF_W-1:0] source2_ref;
    logic             second_input_invert;
    logic             output_invert;
    logic [15:0]      output_delay_time;
    logic [REF_W-1:0] next_source1_ref;
    logic [REF_W-1:0] next_source2_ref;
    logic             next_second_input_invert;
    logic             next_output_invert;
    logic [15:0]      next_output_delay_time;
    logic [REF_W-1:0] next_dest_ref;
    logic [31:0]      next_prdata;
    logic [PARAM_BITS-1:0] sync1;
    logic [PARAM_BITS-1:0] sync2;
    logic             src1;
    logic             src2;
    logic             combined;
    logic             selector_result;
    logic             access;
    logic             known;

    assign access = psel & penable;
    assign pready = 1'h1;

    always_comb begin
        unique case (paddr)
            OFS_SOURCE2_REF, OFS_SRC2_INVERT, OFS_OUT_INVERT,
            OFS_DELAY_TIME, OFS_DEST_REF, OFS_SOURCE1_REF, OFS_RESULT: known = 1'h1;
            default: known = 1'h0;
        endcase
        pslverr = access & ~known;
    end

    // Register writes
    always_comb begin
        next_source1_ref = source1_ref;
        next_source2_ref = source2_ref;
        next_second_input_invert = second_input_invert;
        next_output_invert = output_invert;
        next_output_delay_time = output_delay_time;
        next_dest_ref = dest_ref;
        if (access && pwrite) begin
            unique case (paddr)
                OFS_SOURCE1_REF: next_source1_ref = pwdata[REF_W-1:0];
                OFS_SOURCE2_REF: next_source2_ref = pwdata[REF_W-1:0];   // RL1
                OFS_SRC2_INVERT: next_second_input_invert = pwdata[0];   // RL3
                OFS_OUT_INVERT:  next_output_invert = pwdata[0];         // RL4
                OFS_DELAY_TIME:  next_output_delay_time = pwdata[15:0];  // RL7
                OFS_DEST_REF:    next_dest_ref = pwdata[REF_W-1:0];      // RL10
                default: next_source1_ref = source1_ref;
            endcase
        end
    end

    // Read data
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFS_SOURCE1_REF: next_prdata = {18'h0, source1_ref};
                OFS_SOURCE2_REF: next_prdata = {18'h0, source2_ref};
                OFS_SRC2_INVERT: next_prdata = {31'h0, second_input_invert};
                OFS_OUT_INVERT:  next_prdata = {31'h0, output_invert};
                OFS_DELAY_TIME:  next_prdata = {16'h0, output_delay_time};
                OFS_DEST_REF:    next_prdata = {18'h0, dest_ref};
                OFS_RESULT:      next_prdata = {31'h0, selector_result};   // RL9
                default:         next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source1_ref <= UNUSED_REF;
            source2_ref <= UNUSED_REF;
            second_input_invert <= SRC2_INVERT_RST;
            output_invert <= OUT_INVERT_RST;
            output_delay_time <= DELAY_TIME_RST;
            dest_ref <= UNUSED_REF;
            prdata <= 32'h0;
        end else begin
            source1_ref <= next_source1_ref;
            source2_ref <= next_source2_ref;
            second_input_invert <= next_second_input_invert;
            output_invert <= next_output_invert;
            output_delay_time <= next_output_delay_time;
            dest_ref <= next_dest_ref;
            prdata <= next_prdata;
        end
    end

    // Two-stage sync of the parameter bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= param_bits;
            sync2 <= sync1;
        end
    end

    // Source selection and combination
    always_comb begin
        src1 = (source1_ref == UNUSED_REF) ? 1'h1 : sync2[source1_ref];
        src2 = (source2_ref == UNUSED_REF) ? 1'h1 : sync2[source2_ref];   // RL1 RL2
        src2 = src2 ^ second_input_invert;                                // RL3
        combined = (src1 & src2) ^ output_invert;                        // RL11 RL4
    end

    pbsd_delay #(
        .TICK (TICK)
    ) u_delay (
        .pclk    (pclk),
        .presetn (presetn),
        .cond    (combined),
        .delay   (output_delay_time),
        .q       (selector_result)
    );

    // Unused destination drives nothing
    always_comb begin
        dest_value = selector_result;
        dest_enable = (dest_ref != UNUSED_REF);                          // RL10
    end
endmodule : pbsd_top

// ---- pbsd_checker.sv ----
`timescale 1ns/1ps
module pbsd_checker
    import pbsd_pkg::*;
(
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // Destination
    input wire logic [13:0] dest_ref,
    input wire logic        dest_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire rdc = acc && !pwrite;
    wire hit = paddr <= OFS_RESULT && paddr[1:0] == 2'h0;
    a_zero_wait: assert property (psel |-> pready) else $error("pready low");
    a_err_unmap: assert property (acc && paddr > OFS_RESULT |-> pslverr) else $error("no err");
    a_err_mapped: assert property (acc && hit |-> !pslverr) else $error("false err");
    a_dest_en: assert property (dest_enable == (dest_ref != 14'h0)) else $error("dest en");
    a_dest_write: assert property (acc && pwrite && paddr == OFS_DEST_REF |=>
        dest_ref == $past(pwdata[13:0])) else $error("dest ref");
    a_inv_width: assert property (rdc && (paddr == OFS_SRC2_INVERT || paddr == OFS_OUT_INVERT)
        |-> prdata[31:1] == 31'h0) else $error("inv width");
    a_delay_width: assert property (rdc && paddr == OFS_DELAY_TIME |-> prdata[31:16] == 16'h0)
        else $error("delay width");
    a_result_bit: assert property (rdc && paddr == OFS_RESULT |-> prdata[31:1] == 31'h0)
        else $error("result width");
    a_unmap_zero: assert property (rdc && paddr > OFS_RESULT |-> prdata == 32'h0)
        else $error("unmapped data");
endmodule : pbsd_checker

bind pbsd_top pbsd_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .dest_ref(dest_ref), .dest_enable(dest_enable));

// ---- programmable_bit_selector_delay_tb.sv ----
`timescale 1ns/1ps
module programmable_bit_selector_delay_tb;
    import pbsd_pkg::*;
    localparam int TK = 4;
    localparam logic [11:0] OFS [5] = '{OFS_SOURCE2_REF, OFS_SRC2_INVERT, OFS_OUT_INVERT,
        OFS_DELAY_TIME, OFS_DEST_REF};
    localparam logic [31:0] MSK [5] = '{32'h3FFF, 32'h1, 32'h1, 32'hFFFF, 32'h3FFF};
    logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]    paddr = 0;
    logic [31:0]    pwdata = 0, prdata, rd;
    logic           pready, pslverr, er, dest_value, dest_enable, ex;
    logic [16383:0] param_bits = 0;
    logic [13:0]    dest_ref;
    int             mismatches = 0, compares = 0, seed = 32'h33460b8b;
    int             r1, r2, i2, io, c, v;
    pbsd_top #(.TICK(TK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .param_bits(param_bits), .dest_ref(dest_ref),
        .dest_value(dest_value), .dest_enable(dest_enable));
    initial forever #25 pclk = ~pclk;
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", s, x, g);
        end
    endtask : chk
    function automatic logic sb(input int r);
        return (r == 0) ? 1'b1 : param_bits[r];
    endfunction : sb
    // Cycles until the result follows bit 5
    task automatic dly(input logic b);
        param_bits[5] <= b;
        for (c = 0; c < 100 && dest_value !== b; c++) @(negedge pclk);
        chk("delay", 1, c >= 3 * TK && c <= 4 * TK + 5);
    endtask : dly
    task automatic print_verdict();
        if (mismatches == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    initial begin
        #500us;
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        for (int k = 0; k < 5; k++) begin
            apb(0, OFS[k], 0);
            chk("reset", 0, rd);
            v = $random(seed);
            apb(1, OFS[k], v);
            apb(0, OFS[k], 0);
            chk("readback", v & MSK[k], rd);
        end
        apb(1, 12'h01C, 32'hFFFF);
        chk("unmapped", 1, er);
        apb(1, OFS_DELAY_TIME, 0);
        for (int t = 0; t < 40; t++) begin
            for (int j = 0; j < 512; j++) param_bits[j*32+:32] <= $random(seed);
            r1 = (t % 4 == 0) ? 0 : $unsigned($random(seed)) % 16384;
            r2 = (t % 5 == 0) ? 0 : $unsigned($random(seed)) % 16384;
            i2 = $random(seed) & 1;
            io = $random(seed) & 1;
            apb(1, OFS_SOURCE1_REF, r1);
            apb(1, OFS_SOURCE2_REF, r2);
            apb(1, OFS_SRC2_INVERT, i2);
            apb(1, OFS_OUT_INVERT, io);
            apb(1, OFS_DEST_REF, r2);
            apb(1, OFS_RESULT, 32'h0);
            repeat (5) @(posedge pclk);
            ex = (sb(r1) & (sb(r2) ^ i2[0])) ^ io[0];
            chk("dest_value", ex, dest_value);
            apb(0, OFS_RESULT, 0);
            chk("result", ex, rd);
        end
        apb(0, 12'h01C, 0);
        chk("unmapped_rd", 32'h1, {rd[30:0], er});
        param_bits[5] <= 0;
        apb(1, OFS_SOURCE1_REF, 0);
        apb(1, OFS_SOURCE2_REF, 5);
        apb(1, OFS_SRC2_INVERT, 0);
        apb(1, OFS_OUT_INVERT, 0);
        apb(1, OFS_DELAY_TIME, 3);
        repeat (30) @(posedge pclk);
        dly(1);
        apb(1, OFS_DELAY_TIME, 32'hFFFD);
        repeat (30) @(posedge pclk);
        dly(0);
        print_verdict();
    end
endmodule : programmable_bit_selector_delay_tb
